/* File: src/obc_overtravel_brake.sv */
/*
 Overtravel and holding-brake control for a servo drive, with a classic
 Wishbone slave for its parameters. Assumes limit inputs are asynchronous
 pins, speed and direction come from the drive's own logic on ref_clk.
*/
// Operation
// RULE_01: Forward limit low allows forward motion; high blocks it.
// RULE_02: Reverse limit low allows reverse motion; high blocks it.
// RULE_03: Motion away from an active limit stays allowed during overtravel.
// RULE_04: Overtravel stop keeps position error; the clear input discards it.
// RULE_05: One enable digit makes the forward limit ignored entirely.
// RULE_06: Another enable digit makes the reverse limit ignored entirely.
// RULE_07: Enable and stop method changes apply only after a power reload.
// RULE_08: Method zero: dynamic brake on servo off and overtravel, then coast.
// RULE_09: Method one: coast to stop like servo off, then coast.
// RULE_10: Methods 2-5 plug brake on overtravel; servo off and after vary.
// RULE_11: Zero clamp holds the motor with a position loop around zero.
// RULE_12: Plug braking torque capped by percent limit, 0 to 300, default 300.
// RULE_13: Brake interlock low releases the brake, high applies it.
// RULE_14: Brake interlock reaches no terminal until allocated.
// RULE_15: Speed-loop controller: servo off, zero reference while braked.
// RULE_16: Position-loop controller avoids mechanical brake while servolocked.
// RULE_17: Controller uses the holding brake only to hold a stopped motor.
// RULE_18: Allocation digit value four routes the brake to that terminal pair.
// RULE_19: After servo off, brake applies below wait speed or after wait time.
// RULE_20: Limit inputs pass two synchronising flip-flops before use.
`default_nettype none
module obc_overtravel_brake #(
    parameter int WAIT_UNIT_CYC = obc_pkg::WAIT_UNIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic forward_limit_in,
    input wire logic reverse_limit_in,
    input wire logic error_pulse_clear_in,
    input wire logic fwd_request,
    input wire logic rev_request,
    input wire logic [15:0] motor_speed,
    output logic fwd_allow,
    output logic rev_allow,
    output logic short_circuit_braking,
    output logic plug_braking,
    output logic [15:0] torque_limit,
    output logic power_on,
    output logic zero_clamp,
    output logic hold_error,
    output logic [2:0] out_terminal,
    output logic [2:0] out_terminal_oe
);
    logic [15:0] ot_enable_q, stop_sel_q, torque_q, alloc_q;
    logic [15:0] wspeed_q, wtime_q;
    logic [15:0] ot_enable_act_q, stop_sel_act_q;
    logic servo_on_q, pos_mode_q;
    logic [1:0] fwd_sync_q, rev_sync_q;
    obc_pkg::obc_state_t state_q;
    logic ot_stop_q;
    logic [31:0] unit_cnt_q;
    logic [15:0] wait_cnt_q;
    logic brake_q;
    logic wr, rd_hit;
    logic fwd_ot, rev_ot, ot_move;
    obc_pkg::obc_stop_t method;
    logic servo_off_db, after_clamp;
    logic [15:0] ctl_word, stat_word;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

    // Two-stage synchronisers; only the second stage is read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fwd_sync_q <= 2'h0;
            rev_sync_q <= 2'h0;
        end else begin
            fwd_sync_q <= {fwd_sync_q[0], forward_limit_in}; // [RULE_20]
            rev_sync_q <= {rev_sync_q[0], reverse_limit_in}; // [RULE_20]
        end
    end

    // A disabled limit is forced inactive
    assign fwd_ot = fwd_sync_q[1] &
        ~ot_enable_act_q[obc_pkg::OTE_FWD_BIT]; // [RULE_01] [RULE_05]
    assign rev_ot = rev_sync_q[1] &
        ~ot_enable_act_q[obc_pkg::OTE_REV_BIT]; // [RULE_02] [RULE_06]
    // Overtravel only stops the motor if it moves into the limit
    assign ot_move = (fwd_ot & fwd_request) | (rev_ot & rev_request);
    assign method = obc_pkg::obc_stop_t'(stop_sel_act_q[2:0]);
    assign servo_off_db = (method == obc_pkg::OBC_SM_DB) |
        (method == obc_pkg::OBC_SM_PLUG_DB_COAST) |
        (method == obc_pkg::OBC_SM_PLUG_DB_CLAMP);
    assign after_clamp = (method == obc_pkg::OBC_SM_PLUG_DB_CLAMP) |
        (method == obc_pkg::OBC_SM_PLUG_CO_CLAMP);

    // Register writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ot_enable_q <= obc_pkg::OT_ENABLE_RST;
            stop_sel_q <= obc_pkg::STOP_SEL_RST;
            torque_q <= obc_pkg::TORQUE_LIM_RST;
            alloc_q <= obc_pkg::OUT_ALLOC_RST;
            wspeed_q <= obc_pkg::WAIT_SPEED_RST;
            wtime_q <= obc_pkg::WAIT_TIME_RST;
            servo_on_q <= 1'b0;
            pos_mode_q <= 1'b0;
        end else if (wr) begin
            case (wb_adr_i)
                obc_pkg::REG_OT_ENABLE: begin
                    if (wb_sel_i[0]) ot_enable_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) ot_enable_q[15:8] <= wb_dat_i[15:8];
                end
                obc_pkg::REG_STOP_SEL: begin
                    if (wb_sel_i[0]) stop_sel_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) stop_sel_q[15:8] <= wb_dat_i[15:8];
                end
                obc_pkg::REG_TORQUE_LIM: begin
                    if (wb_sel_i[0]) torque_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) torque_q[15:8] <= wb_dat_i[15:8];
                end
                obc_pkg::REG_OUT_ALLOC: begin
                    if (wb_sel_i[0]) alloc_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) alloc_q[15:8] <= wb_dat_i[15:8];
                end
                obc_pkg::REG_WAIT_SPEED: begin
                    if (wb_sel_i[0]) wspeed_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) wspeed_q[15:8] <= wb_dat_i[15:8];
                end
                obc_pkg::REG_WAIT_TIME: begin
                    if (wb_sel_i[0]) wtime_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) wtime_q[15:8] <= wb_dat_i[15:8];
                end
                obc_pkg::REG_CONTROL: begin
                    if (wb_sel_i[0]) begin
                        servo_on_q <= wb_dat_i[obc_pkg::CTL_SERVO_ON_BIT];
                        pos_mode_q <= wb_dat_i[obc_pkg::CTL_POS_MODE_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Active copies load at reset or on the reload strobe, which stands in
    // for a power cycle; live writes to those two registers alone never change behaviour
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ot_enable_act_q <= obc_pkg::OT_ENABLE_RST;
            stop_sel_act_q <= obc_pkg::STOP_SEL_RST;
        end else if (wr && wb_adr_i == obc_pkg::REG_CONTROL && wb_sel_i[0]
                     && wb_dat_i[obc_pkg::CTL_RELOAD_BIT]) begin
            ot_enable_act_q <= ot_enable_q; // [RULE_07]
            stop_sel_act_q <= stop_sel_q; // [RULE_07]
        end
    end

    // Stop sequencing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= obc_pkg::OBC_IDLE;
            ot_stop_q <= 1'b0;
        end else begin
            case (state_q)
                obc_pkg::OBC_IDLE: begin
                    if (servo_on_q) state_q <= obc_pkg::OBC_RUN;
                end
                obc_pkg::OBC_RUN: begin
                    if (!servo_on_q) begin
                        state_q <= obc_pkg::OBC_STOPPING;
                        ot_stop_q <= 1'b0;
                    end else if (ot_move) begin
                        state_q <= obc_pkg::OBC_STOPPING;
                        ot_stop_q <= 1'b1;
                    end
                end
                obc_pkg::OBC_STOPPING: begin
                    if (motor_speed == 16'h0000)
                        state_q <= obc_pkg::OBC_STOPPED;
                end
                obc_pkg::OBC_STOPPED: begin
                    // Overtravel stop resumes once the request leaves the limit
                    if (!servo_on_q) begin
                        state_q <= obc_pkg::OBC_IDLE;
                    end else if (ot_stop_q && !ot_move) begin
                        state_q <= obc_pkg::OBC_RUN; // [RULE_03]
                        ot_stop_q <= 1'b0;
                    end
                end
                default: state_q <= obc_pkg::OBC_IDLE;
            endcase
        end
    end

    // Braking outputs per stop method
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            short_circuit_braking <= 1'b0;
            plug_braking <= 1'b0;
            power_on <= 1'b0;
            zero_clamp <= 1'b0;
            torque_limit <= obc_pkg::TORQUE_LIM_RST;
        end else begin
            short_circuit_braking <= 1'b0;
            plug_braking <= 1'b0;
            power_on <= state_q == obc_pkg::OBC_RUN;
            zero_clamp <= 1'b0;
            torque_limit <= torque_q > obc_pkg::TORQUE_LIM_MAX ?
                obc_pkg::TORQUE_LIM_MAX : torque_q; // [RULE_12]
            if (state_q == obc_pkg::OBC_STOPPING) begin
                if (ot_stop_q &&
                    method >= obc_pkg::OBC_SM_PLUG_DB_COAST) begin
                    plug_braking <= 1'b1; // [RULE_10] [RULE_12]
                    power_on <= 1'b1;
                end else if (ot_stop_q) begin
                    short_circuit_braking <=
                        method == obc_pkg::OBC_SM_DB; // [RULE_08] [RULE_09]
                end else begin
                    short_circuit_braking <= servo_off_db; // [RULE_10]
                end
            end
            // Clamp after an overtravel stop keeps the loop closed on zero
            if (state_q == obc_pkg::OBC_STOPPED && ot_stop_q &&
                after_clamp) begin
                zero_clamp <= 1'b1; // [RULE_10] [RULE_11]
                power_on <= 1'b1;
            end
        end
    end

    // Motion permission and position error hold
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fwd_allow <= 1'b0;
            rev_allow <= 1'b0;
            hold_error <= 1'b0;
        end else begin
            fwd_allow <= ~fwd_ot & (state_q == obc_pkg::OBC_RUN); // [RULE_01]
            rev_allow <= ~rev_ot & (state_q == obc_pkg::OBC_RUN); // [RULE_02]
            // Set wins over a clear arriving in the same cycle
            if (state_q == obc_pkg::OBC_STOPPING && ot_stop_q && pos_mode_q)
                hold_error <= 1'b1; // [RULE_04]
            else if (error_pulse_clear_in)
                hold_error <= 1'b0; // [RULE_04]
        end
    end

    // Brake waiting timer in 10 ms units after servo off
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unit_cnt_q <= 32'h0;
            wait_cnt_q <= 16'h0;
            brake_q <= 1'b1;
        end else if (servo_on_q) begin
            unit_cnt_q <= 32'h0;
            wait_cnt_q <= 16'h0;
            brake_q <= 1'b0;
        end else if (!brake_q) begin
            if (unit_cnt_q == 32'(WAIT_UNIT_CYC - 1)) begin
                unit_cnt_q <= 32'h0;
                wait_cnt_q <= wait_cnt_q + 16'h1;
            end else begin
                unit_cnt_q <= unit_cnt_q + 32'h1;
            end
            if (motor_speed < wspeed_q || wait_cnt_q >= wtime_q)
                brake_q <= 1'b1; // [RULE_19]
        end
    end

    // Terminal drive: a digit equal to four carries the interlock there
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_terminal <= 3'h0;
            out_terminal_oe <= 3'h0;
        end else begin
            for (int i = 0; i < obc_pkg::ALLOC_DIGITS; i++) begin
                out_terminal_oe[i] <= // [RULE_14] [RULE_18]
                    alloc_q[4*i +: 4] == obc_pkg::ALLOC_BRAKE;
                out_terminal[i] <= alloc_q[4*i +: 4] == obc_pkg::ALLOC_BRAKE
                    ? brake_q : 1'b0; // [RULE_13] [RULE_18]
            end
        end
    end

    assign ctl_word = {13'h0, 1'b0, pos_mode_q, servo_on_q};
    assign stat_word = {8'h0, brake_q, hold_error, zero_clamp, ot_stop_q,
                        rev_ot, fwd_ot, state_q};
    assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

    // Wishbone answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (rd_hit) begin
                case (wb_adr_i)
                    obc_pkg::REG_OT_ENABLE: wb_dat_o <= {16'h0, ot_enable_q};
                    obc_pkg::REG_STOP_SEL: wb_dat_o <= {16'h0, stop_sel_q};
                    obc_pkg::REG_TORQUE_LIM: wb_dat_o <= {16'h0, torque_q};
                    obc_pkg::REG_OUT_ALLOC: wb_dat_o <= {16'h0, alloc_q};
                    obc_pkg::REG_WAIT_SPEED: wb_dat_o <= {16'h0, wspeed_q};
                    obc_pkg::REG_WAIT_TIME: wb_dat_o <= {16'h0, wtime_q};
                    obc_pkg::REG_CONTROL: wb_dat_o <= {16'h0, ctl_word};
                    obc_pkg::REG_STATUS: wb_dat_o <= {16'h0, stat_word};
                    obc_pkg::REG_SPEED: wb_dat_o <= {16'h0, motor_speed};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end
endmodule // obc_overtravel_brake
`default_nettype wire

/* File: pkg/obc_pkg.sv */
/*
 Package for the overtravel and brake control block: register offsets,
 field positions, reset values, stop-method codes and timing counts.
 Assumes a 50 MHz ref_clk and a 32-bit classic Wishbone register bus.
*/
`default_nettype none
package obc_pkg;
    localparam int CLK_HZ = 50_000_000;
    // Register byte offsets
    localparam logic [7:0] REG_OT_ENABLE = 8'h00;
    localparam logic [7:0] REG_STOP_SEL = 8'h04;
    localparam logic [7:0] REG_TORQUE_LIM = 8'h08;
    localparam logic [7:0] REG_OUT_ALLOC = 8'h0c;
    localparam logic [7:0] REG_WAIT_SPEED = 8'h10;
    localparam logic [7:0] REG_WAIT_TIME = 8'h14;
    localparam logic [7:0] REG_CONTROL = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_SPEED = 8'h20;
    // Field positions and allocation digit count
    localparam int OTE_FWD_BIT = 4;
    localparam int OTE_REV_BIT = 8;
    localparam int CTL_SERVO_ON_BIT = 0;
    localparam int CTL_POS_MODE_BIT = 1;
    localparam int CTL_RELOAD_BIT = 2;
    localparam int ALLOC_DIGITS = 3;
    // Reset values, torque cap and brake allocation code
    localparam logic [15:0] OT_ENABLE_RST = 16'h0000;
    localparam logic [15:0] STOP_SEL_RST = 16'h0000;
    localparam logic [15:0] TORQUE_LIM_RST = 16'h012c;
    localparam logic [15:0] TORQUE_LIM_MAX = 16'h012c;
    localparam logic [15:0] OUT_ALLOC_RST = 16'h0210;
    localparam logic [15:0] WAIT_SPEED_RST = 16'h0064;
    localparam logic [15:0] WAIT_TIME_RST = 16'h0032;
    localparam logic [3:0] ALLOC_BRAKE = 4'h4;
    // Brake waiting time counts in 10 ms units
    localparam int WAIT_UNIT_MS = 10;
    localparam int WAIT_UNIT_CYC = CLK_HZ / 1000 * WAIT_UNIT_MS;
    // Stop methods
    typedef enum logic [2:0] {
        OBC_SM_DB = 3'h0, OBC_SM_COAST = 3'h1, OBC_SM_PLUG_DB_COAST = 3'h2,
        OBC_SM_PLUG_CO_COAST = 3'h3, OBC_SM_PLUG_DB_CLAMP = 3'h4,
        OBC_SM_PLUG_CO_CLAMP = 3'h5
    } obc_stop_t;
    // Drive states, Gray coded along run -> stopping -> stopped
    typedef enum logic [1:0] {
        OBC_RUN = 2'b00, OBC_STOPPING = 2'b01, OBC_STOPPED = 2'b11,
        OBC_IDLE = 2'b10
    } obc_state_t;
endpackage
`default_nettype wire

/* File: verification/obc_assertions.sv */
/*
 Checker for the overtravel brake block: bus handshake and output
 consistency. Sees only the top module's ports; bound from the bench.
*/
`default_nettype none
module obc_assertions #(
    parameter int WAIT_UNIT_CYC = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic error_pulse_clear_in,
    input wire logic fwd_allow,
    input wire logic rev_allow,
    input wire logic short_circuit_braking,
    input wire logic plug_braking,
    input wire logic [15:0] torque_limit,
    input wire logic power_on,
    input wire logic zero_clamp,
    input wire logic hold_error,
    input wire logic [2:0] out_terminal,
    input wire logic [2:0] out_terminal_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_answer: assert property (s_req |=> s_answer)
        else $error("bus request not answered by one ack pulse");
    a_torque_cap: assert property (torque_limit <= 16'h012c)
        else $error("torque limit above 300 percent");
    a_fwd_block: assert property (fwd_allow |->
        !short_circuit_braking && !plug_braking && !zero_clamp)
        else $error("forward motion allowed while stopping");
    a_rev_block: assert property (rev_allow |->
        !short_circuit_braking && !plug_braking && !zero_clamp)
        else $error("reverse motion allowed while stopping");
    a_plug_power: assert property (plug_braking |->
        power_on && !short_circuit_braking)
        else $error("plug braking without motor power");
    a_db_unpowered: assert property (
        short_circuit_braking |-> !power_on)
        else $error("dynamic brake with motor powered");
    a_clamp_hold: assert property (
        zero_clamp |-> power_on && !plug_braking)
        else $error("zero clamp without position hold");
    a_brake_route: assert property (
        (out_terminal & ~out_terminal_oe) == 3'h0)
        else $error("brake level on unallocated terminal");
    a_error_kept: assert property ($fell(hold_error) |->
        $past(error_pulse_clear_in))
        else $error("position error dropped without clear");
endmodule // obc_assertions
`default_nettype wire

/* File: verification/obc_partner.sv */
/*
 Far side model: motor mechanics, limit switches and brake relay.
 Assumes the bench commands the switches; pins are registered here.
*/
`default_nettype none
module obc_partner (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic fwd_hit,
    input wire logic rev_hit,
    input wire logic fwd_request,
    input wire logic rev_request,
    input wire logic fwd_allow,
    input wire logic rev_allow,
    input wire logic power_on,
    input wire logic plug_braking,
    input wire logic short_circuit_braking,
    input wire logic [2:0] out_terminal,
    input wire logic [2:0] out_terminal_oe,
    output logic forward_limit_in,
    output logic reverse_limit_in,
    output logic [15:0] motor_speed,
    output logic brake_engaged
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drive;
    logic [15:0] drop;
    assign drive = power_on && !plug_braking &&
        (fwd_request && fwd_allow || rev_request && rev_allow);
    // Plug braking stops hardest; coasting relies on friction alone
    assign drop = plug_braking ? 16'h0020 :
        short_circuit_braking ? 16'h0010 : 16'h0001;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            motor_speed <= 16'h0000;
        end else if (drive) begin
            motor_speed <= (motor_speed > 16'h00c0) ? 16'h00c8 :
                motor_speed + 16'h0008;
        end else begin
            motor_speed <= (motor_speed > drop) ? motor_speed - drop : 16'h0;
        end
    end
    // A tripped switch opens and its pin is pulled high
    always_ff @(posedge ref_clk) begin
        forward_limit_in <= fwd_hit;
        reverse_limit_in <= rev_hit;
    end
    // Relay applies the brake while its allocated pin is high
    assign brake_engaged = |(out_terminal & out_terminal_oe);
endmodule // obc_partner
`default_nettype wire

/* File: verification/obc_overtravel_brake_test.sv */
/*
 Bench for the overtravel brake block: registers, stop methods, limit
 ignore digits and brake timing. Assumes partner and checker files.
*/
`default_nettype none
module obc_overtravel_brake_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, cyc, stb, we, ack, clr, freq, rreq;
    logic fhit, rhit, flim, rlim, fal, ral, db, plug, pwr, zc, herr, brk;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] speed, tlim;
    logic [2:0] term, term_oe;
    int error_cnt = 0;
    int compares = 0;
    obc_overtravel_brake #(.WAIT_UNIT_CYC(10)) i_obc_overtravel_brake (
        .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .forward_limit_in(flim),
        .reverse_limit_in(rlim), .error_pulse_clear_in(clr),
        .fwd_request(freq), .rev_request(rreq), .motor_speed(speed),
        .fwd_allow(fal), .rev_allow(ral), .short_circuit_braking(db),
        .plug_braking(plug), .torque_limit(tlim), .power_on(pwr),
        .zero_clamp(zc), .hold_error(herr), .out_terminal(term),
        .out_terminal_oe(term_oe));
    obc_partner i_obc_partner (.ref_clk(ref_clk), .rst(rst), .fwd_hit(fhit),
        .rev_hit(rhit), .fwd_request(freq), .rev_request(rreq),
        .fwd_allow(fal), .rev_allow(ral), .power_on(pwr), .plug_braking(plug),
        .short_circuit_braking(db), .out_terminal(term),
        .out_terminal_oe(term_oe), .forward_limit_in(flim),
        .reverse_limit_in(rlim), .motor_speed(speed), .brake_engaged(brk));
    task automatic end_of_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h3;
        adr <= a;
        wdat <= d;
        // Request held until ack is sampled high at a rising edge
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_check(input string what, input logic [7:0] a,
            input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask
    task automatic wait_speed(input logic zero);
        int n;
        n = 0;
        while ((zero ? speed !== 16'h0 : speed < 16'h00c0) && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 400) error_cnt++;
    endtask
    task automatic t_regs();
        rd_check("torque reg", obc_pkg::REG_TORQUE_LIM, 32'h012c);
        rd_check("alloc reg", obc_pkg::REG_OUT_ALLOC, 32'h0210);
        rd_check("wait speed", obc_pkg::REG_WAIT_SPEED, 32'h0064);
        rd_check("wait time", obc_pkg::REG_WAIT_TIME, 32'h0032);
        check("terminal oe", term_oe, 3'h0);
        wr(8'h24, 32'hffff);
        rd_check("unmapped", 8'h24, 32'h0);
        wr(obc_pkg::REG_TORQUE_LIM, 32'h0064);
        repeat (2) @(posedge ref_clk);
        check("torque set", tlim, 16'h0064);
        wr(obc_pkg::REG_TORQUE_LIM, 32'h0190);
        repeat (2) @(posedge ref_clk);
        check("torque clamp", tlim, 16'h012c);
    endtask
    task automatic t_stop(input logic [2:0] m);
        wr(obc_pkg::REG_STOP_SEL, {29'h0, m});
        wr(obc_pkg::REG_CONTROL, 32'h4);
        wr(obc_pkg::REG_CONTROL, 32'h3);
        freq <= 1'b1;
        wait_speed(1'b0);
        fhit <= 1'b1;
        repeat (7) @(posedge ref_clk);
        check("fwd allow", fal, 1'b0);
        check("plug", plug, m >= 3'h2);
        check("db", db, m == 3'h0);
        check("held error", herr, 1'b1);
        wait_speed(1'b1);
        repeat (4) @(posedge ref_clk);
        check("zero clamp", zc, m >= 3'h4);
        check("power", pwr, m >= 3'h4);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check("cleared", herr, 1'b0);
        freq <= 1'b0;
        rreq <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check("rev in ot", ral, 1'b1);
        rreq <= 1'b0;
        fhit <= 1'b0;
        wr(obc_pkg::REG_CONTROL, 32'h0);
        repeat (2) @(posedge ref_clk);
        check("servo off db", db, m[0] == 1'b0);
        wait_speed(1'b1);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic t_ignore();
        wr(obc_pkg::REG_CONTROL, 32'h3);
        rhit <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("rev sync", ral, 1'b1);
        repeat (3) @(posedge ref_clk);
        check("rev blocked", ral, 1'b0);
        fhit <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("fwd blocked", fal, 1'b0);
        wr(obc_pkg::REG_OT_ENABLE, 32'h0110);
        repeat (4) @(posedge ref_clk);
        check("no reload", fal, 1'b0);
        wr(obc_pkg::REG_CONTROL, 32'h7);
        repeat (4) @(posedge ref_clk);
        check("fwd ignored", fal, 1'b1);
        check("rev ignored", ral, 1'b1);
        fhit <= 1'b0;
        rhit <= 1'b0;
        wr(obc_pkg::REG_OT_ENABLE, 32'h0);
        wr(obc_pkg::REG_CONTROL, 32'h4);
    endtask
    // Either the wait time or the wait speed ends the wait near 100 cycles
    task automatic t_brake(input logic [15:0] spd, input logic [15:0] tim);
        int n;
        n = 0;
        wr(obc_pkg::REG_WAIT_SPEED, {16'h0, spd});
        wr(obc_pkg::REG_WAIT_TIME, {16'h0, tim});
        wr(obc_pkg::REG_CONTROL, 32'h1);
        freq <= 1'b1;
        wait_speed(1'b0);
        check("released", brk, 1'b0);
        freq <= 1'b0;
        wr(obc_pkg::REG_CONTROL, 32'h0);
        while (brk !== 1'b1 && n < 130) begin
            @(posedge ref_clk);
            n++;
        end
        check("brake time", n >= 90 && n < 130, 1'b1);
        wait_speed(1'b1);
        repeat (4) @(posedge ref_clk);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, cyc, stb, we, clr, freq, rreq, fhit, rhit} = 9'h100;
        adr = 8'h0;
        sel = 4'h3;
        wdat = 32'h0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        for (logic [3:0] m = 4'h0; m < 4'h6; m++) t_stop(m[2:0]);
        t_ignore();
        wr(obc_pkg::REG_STOP_SEL, 32'h1);
        wr(obc_pkg::REG_CONTROL, 32'h4);
        wr(obc_pkg::REG_OUT_ALLOC, 32'h0004);
        repeat (2) @(posedge ref_clk);
        check("alloc oe", term_oe, 3'h1);
        t_brake(16'h000a, 16'h000a);
        t_brake(16'h0064, 16'h0064);
        end_of_test();
    end
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule // obc_overtravel_brake_test
bind obc_overtravel_brake obc_assertions #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC))
    i_obc_assertions (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fwd_allow(fwd_allow),
    .error_pulse_clear_in(error_pulse_clear_in), .rev_allow(rev_allow),
    .short_circuit_braking(short_circuit_braking), .power_on(power_on),
    .plug_braking(plug_braking), .torque_limit(torque_limit),
    .zero_clamp(zero_clamp), .hold_error(hold_error),
    .out_terminal(out_terminal), .out_terminal_oe(out_terminal_oe));
`default_nettype wire
